//--- irl_pkg.sv
// Constants, register map and carrier types for the interrupt response logic.
// Assumes one 40 MHz system clock and a 32-bit AHB-Lite register port.
package irl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_ENABLE   = 8'h00;
  localparam logic [7:0] ADDR_PRIORITY = 8'h04;
  localparam logic [7:0] ADDR_FLAGS    = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam int         ADDR_BITS     = 8;

  // Source slots in polling order; slot 5 has a vector but no source
  localparam int NUM_SLOTS  = 7;
  localparam int SLOT_EXT0  = 0;
  localparam int SLOT_TMR0  = 1;
  localparam int SLOT_EXT1  = 2;
  localparam int SLOT_TMR1  = 3;
  localparam int SLOT_UART  = 4;
  localparam int SLOT_NONE  = 5;
  localparam int SLOT_LVD   = 6;
  localparam int SLOT_W     = 3;

  // Enable and priority share the slot layout, global enable on top
  localparam int BIT_GLOBAL_ENABLE = 7;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'h00;
  localparam logic [6:0] SLOT_MASK      = 7'h5F;

  // Flags register fields
  localparam int BIT_EXT0_EDGE = 0;
  localparam int BIT_EXT0_FLAG = 1;
  localparam int BIT_EXT1_EDGE = 2;
  localparam int BIT_EXT1_FLAG = 3;
  localparam int BIT_TMR0_FLAG = 5;
  localparam int BIT_TMR1_FLAG = 7;
  localparam int BIT_UART_RX   = 8;
  localparam int BIT_UART_TX   = 9;
  localparam int BIT_LVD_FLAG  = 10;

  // Vector of each slot
  localparam logic [NUM_SLOTS-1:0][15:0] VECTOR_TABLE = {
    16'h0033, 16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

  // Hardware call length and the cycles within it
  localparam int         CALL_CYCLES  = 6;
  localparam logic [2:0] CALL_LAST    = 3'(CALL_CYCLES - 1);
  localparam logic [2:0] CALL_PUSH_LO = 3'h1;
  localparam logic [2:0] CALL_PUSH_HI = 3'h2;
  localparam logic [2:0] CALL_LOAD_PC = 3'h4;

  typedef enum logic [0:0] {IRL_IDLE, IRL_CALL} irl_state_t;

  // Instruction status from the core, same clock
  typedef struct packed {
    logic        opcode_fetch;
    logic        last_cycle;
    logic        return_from_interrupt;
    logic        subroutine_exit;
    logic        enable_priority_write;
    logic        flash_self_programming;
    logic [15:0] pc;
  } irl_core_t;

  // Hardware call sequence towards the core
  typedef struct packed {
    logic        busy;
    logic        push;
    logic [7:0]  push_byte;
    logic        pc_load;
    logic [15:0] pc_addr;
  } irl_call_t;

endpackage : irl_pkg

//--- irl_interrupt_response.sv
// Interrupt acknowledge logic: flag capture, polling, priority, hardware call.
// Assumes the core reports instruction boundaries on clk_sys and stalls during call.busy.
// What this block does
// - Sample request sources at each opcode fetch, evaluate at the next poll.
// - No call while equal or higher priority routine is in progress.
// - Vector only when polling cycle is the last cycle of the instruction.
// - After return-from-interrupt or enable/priority write, run one more instruction first.
// - No call while flash self programming is underway.
// - Polling repeats in the last clock cycle of every instruction.
// - Blocked requests are not remembered; each poll uses current flags only.
// - Acknowledge issues a long call pushing the PC, not the status word.
// - Vectors: ext0 0003H, timer0 000BH, ext1 0013H.
// - Vectors: timer1 001BH, serial 0023H, low voltage 0033H; 002BH unused.
// - Serial receive and transmit flags are never cleared by vectoring.
// - External flag cleared on vectoring only in edge mode; level follows pin.
// - Return-from-interrupt clears the highest in-progress level; core pops two bytes into PC.
// - Plain subroutine exit leaves in-progress state set.
// - Trigger-select 0: low level on the pin raises the request.
// - Trigger-select 1: a high sample then low sample sets the flag.
// - Pin levels are inverted and latched every system clock edge.
// - Timer overflow flags are evaluated on the clock edge after overflow.
// - The hardware call takes six clock cycles.
// - Extra latency at most 3 cycles, or 5 after return/enable access.
// - High preempts low; nothing preempts high; low never preempts low.
// - Same-level order: ext0, timer0, ext1, timer1, serial, low voltage.
// - Timer overflow flag is cleared when its routine is vectored.
module irl_interrupt_response (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // AHB-Lite register port
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Request pins, active low, asynchronous
  input  wire logic [1:0]                    ext_request_pin_n,
  // Peripheral set pulses
  input  wire logic                          timer0_overflow,
  input  wire logic                          timer1_overflow,
  input  wire logic                          uart_receive_set,
  input  wire logic                          uart_transmit_set,
  input  wire logic                          low_voltage_set,
  // Core interface
  input  wire irl_pkg::irl_core_t            core,
  output irl_pkg::irl_call_t                 call,
  output logic      [1:0]                    in_progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0]                  interrupt_enable_register;
  logic [7:0]                  priority_select_register;
  logic                        wr_pend;
  logic [irl_pkg::ADDR_BITS-1:0] wr_addr;
  logic                        addr_phase;
  logic                        wr_enable;
  logic                        wr_priority;
  logic                        wr_flags;

  assign addr_phase  = hsel && htrans[1] && hready;
  assign wr_enable   = wr_pend && (wr_addr == irl_pkg::ADDR_ENABLE);
  assign wr_priority = wr_pend && (wr_addr == irl_pkg::ADDR_PRIORITY);
  assign wr_flags    = wr_pend && (wr_addr == irl_pkg::ADDR_FLAGS);

  // Zero-wait slave, always OKAY
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_phase && hwrite;
      wr_addr   <= haddr[irl_pkg::ADDR_BITS-1:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interrupt_enable_register <= irl_pkg::ENABLE_RESET;
      priority_select_register  <= irl_pkg::PRIORITY_RESET;
    end else begin
      if (wr_enable) begin
        interrupt_enable_register <= hwdata[7:0] & {1'b1, irl_pkg::SLOT_MASK};
      end
      if (wr_priority) begin
        priority_select_register <= hwdata[7:0] & {1'b0, irl_pkg::SLOT_MASK};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pins
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] ext_active;
  logic [1:0] ext_active_prev;
  logic [1:0] ext_fall;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= ext_request_pin_n;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_active      <= 2'h0;
      ext_active_prev <= 2'h0;
    end else begin
      ext_active      <= ~pin_sync;
      ext_active_prev <= ext_active;
    end
  end

  assign ext_fall = ext_active & ~ext_active_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Request flags
  logic [1:0]                   ext_edge_mode;
  logic [1:0]                   ext_flag;
  logic                         timer0_overflow_flag;
  logic                         timer1_overflow_flag;
  logic                         uart_receive_flag;
  logic                         uart_transmit_flag;
  logic                         low_voltage_flag;
  logic                         ack;
  logic [irl_pkg::NUM_SLOTS-1:0] ack_slot;
  logic [1:0]                   ext_wdata;
  logic [1:0]                   ext_edge_wdata;

  assign ext_wdata      = {hwdata[irl_pkg::BIT_EXT1_FLAG], hwdata[irl_pkg::BIT_EXT0_FLAG]};
  assign ext_edge_wdata = {hwdata[irl_pkg::BIT_EXT1_EDGE], hwdata[irl_pkg::BIT_EXT0_EDGE]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_edge_mode <= 2'h0;
      ext_flag      <= 2'h0;
    end else begin
      if (wr_flags) begin
        ext_edge_mode <= ext_edge_wdata;
      end
      for (int i = 0; i < 2; i++) begin
        if (!ext_edge_mode[i]) begin
          ext_flag[i] <= ext_active[i];
        end else begin
          // edge flag cleared on vectoring; set wins over clear
          ext_flag[i] <= (wr_flags ? ext_wdata[i] : (ext_flag[i] && !ack_slot[2*i])) || ext_fall[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      timer0_overflow_flag <= (wr_flags ? hwdata[irl_pkg::BIT_TMR0_FLAG]
                               : (timer0_overflow_flag && !ack_slot[irl_pkg::SLOT_TMR0])) || timer0_overflow;
      timer1_overflow_flag <= (wr_flags ? hwdata[irl_pkg::BIT_TMR1_FLAG]
                               : (timer1_overflow_flag && !ack_slot[irl_pkg::SLOT_TMR1])) || timer1_overflow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      uart_receive_flag  <= 1'b0;
      uart_transmit_flag <= 1'b0;
      low_voltage_flag   <= 1'b0;
    end else begin
      uart_receive_flag  <= (wr_flags ? hwdata[irl_pkg::BIT_UART_RX] : uart_receive_flag) || uart_receive_set;
      uart_transmit_flag <= (wr_flags ? hwdata[irl_pkg::BIT_UART_TX] : uart_transmit_flag) || uart_transmit_set;
      low_voltage_flag   <= (wr_flags ? hwdata[irl_pkg::BIT_LVD_FLAG] : low_voltage_flag) || low_voltage_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling and polling
  logic [irl_pkg::NUM_SLOTS-1:0] live_req;
  logic [irl_pkg::NUM_SLOTS-1:0] sampled_req;
  logic [irl_pkg::NUM_SLOTS-1:0] pending;
  logic [irl_pkg::NUM_SLOTS-1:0] pend_hi;
  logic [irl_pkg::NUM_SLOTS-1:0] pend_lo;
  logic                          hold_one;
  logic                          blocked;
  logic                          poll;
  logic                          sel_valid;
  logic                          sel_level;
  logic [irl_pkg::SLOT_W-1:0]    sel_slot;
  irl_pkg::irl_state_t           state;

  // flags seen the edge after they set
  always_comb begin
    live_req                     = '0;
    live_req[irl_pkg::SLOT_EXT0] = ext_flag[0];
    live_req[irl_pkg::SLOT_TMR0] = timer0_overflow_flag;
    live_req[irl_pkg::SLOT_EXT1] = ext_flag[1];
    live_req[irl_pkg::SLOT_TMR1] = timer1_overflow_flag;
    live_req[irl_pkg::SLOT_UART] = uart_receive_flag || uart_transmit_flag;
    live_req[irl_pkg::SLOT_LVD]  = low_voltage_flag;
    live_req = live_req & interrupt_enable_register[irl_pkg::NUM_SLOTS-1:0]
               & {irl_pkg::NUM_SLOTS{interrupt_enable_register[irl_pkg::BIT_GLOBAL_ENABLE]}};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sampled_req <= '0;
    end else if (core.opcode_fetch) begin
      sampled_req <= live_req;
    end
  end

  // a sample counts only while its flag is still live
  assign pending = sampled_req & live_req;
  assign pend_hi = pending & priority_select_register[irl_pkg::NUM_SLOTS-1:0];
  assign pend_lo = pending & ~priority_select_register[irl_pkg::NUM_SLOTS-1:0];

  // an enable/priority write anywhere in the instruction holds off this poll
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_one <= 1'b0;
    end else if (core.last_cycle) begin
      hold_one <= 1'b0;
    end else if (wr_enable || wr_priority) begin
      hold_one <= 1'b1;
    end
  end

  // level first, then fixed order within level
  always_comb begin
    sel_valid = 1'b0;
    sel_level = 1'b0;
    sel_slot  = '0;
    if (|pend_hi && !in_progress[1]) begin
      sel_valid = 1'b1;
      sel_level = 1'b1;
      for (int i = irl_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
        if (pend_hi[i]) begin
          sel_slot = irl_pkg::SLOT_W'(i);
        end
      end
    end else if (|pend_lo && (in_progress == 2'h0)) begin
      sel_valid = 1'b1;
      for (int i = irl_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
        if (pend_lo[i]) begin
          sel_slot = irl_pkg::SLOT_W'(i);
        end
      end
    end
  end

  // poll in the last cycle of each instruction
  assign poll    = core.last_cycle && (state == irl_pkg::IRL_IDLE);
  assign blocked = core.return_from_interrupt || core.enable_priority_write || hold_one
                   || wr_enable || wr_priority || core.flash_self_programming;
  assign ack     = poll && !blocked && sel_valid;

  always_comb begin
    ack_slot = '0;
    if (ack) begin
      ack_slot[sel_slot] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-progress levels
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_progress <= 2'h0;
    end else if (ack) begin
      in_progress[sel_level] <= 1'b1;
    end else if (core.last_cycle && core.return_from_interrupt) begin
      // highest level retires first; plain exit ignored
      if (in_progress[1]) begin
        in_progress[1] <= 1'b0;
      end else begin
        in_progress[0] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware call
  logic [2:0]                 call_step;
  logic [irl_pkg::SLOT_W-1:0] call_slot;
  logic [15:0]                ret_pc;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= irl_pkg::IRL_IDLE;
      call_step <= 3'h0;
      call_slot <= '0;
      ret_pc    <= 16'h0000;
    end else begin
      case (state)
        irl_pkg::IRL_IDLE: begin
          if (ack) begin
            state     <= irl_pkg::IRL_CALL;
            call_step <= 3'h0;
            call_slot <= sel_slot;
            ret_pc    <= core.pc;
          end
        end
        irl_pkg::IRL_CALL: begin
          if (call_step == irl_pkg::CALL_LAST) begin
            state <= irl_pkg::IRL_IDLE;
          end else begin
            call_step <= call_step + 3'h1;
          end
        end
        default: begin
          state <= irl_pkg::IRL_IDLE;
        end
      endcase
    end
  end

  // push PC low then high, no status word, then load vector
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      call <= '0;
    end else begin
      call.busy      <= ack || (state == irl_pkg::IRL_CALL && call_step != irl_pkg::CALL_LAST);
      call.push      <= (state == irl_pkg::IRL_CALL)
                        && (call_step == irl_pkg::CALL_PUSH_LO - 3'h1 || call_step == irl_pkg::CALL_PUSH_HI - 3'h1);
      call.push_byte <= (call_step == irl_pkg::CALL_PUSH_LO - 3'h1) ? ret_pc[7:0] : ret_pc[15:8];
      call.pc_load   <= (state == irl_pkg::IRL_CALL) && (call_step == irl_pkg::CALL_LOAD_PC - 3'h1);
      call.pc_addr   <= irl_pkg::VECTOR_TABLE[call_slot];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[irl_pkg::ADDR_BITS-1:0])
        irl_pkg::ADDR_ENABLE:   hrdata <= {24'h000000, interrupt_enable_register};
        irl_pkg::ADDR_PRIORITY: hrdata <= {24'h000000, priority_select_register};
        irl_pkg::ADDR_FLAGS:    hrdata <= {21'h000000, low_voltage_flag, uart_transmit_flag, uart_receive_flag,
                                           timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
                                           ext_flag[1], ext_edge_mode[1], ext_flag[0], ext_edge_mode[0]};
        irl_pkg::ADDR_STATUS:   hrdata <= {18'h00000, pending, 1'b0, call_slot, call.busy, in_progress};
        default:                hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_call_six_cycles: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(call.busy) |-> call.busy [*6] ##1 !call.busy)
    else $error("call not six cycles");

  a_vector_slot: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack && sel_slot == 3'h0 |-> ##5 call.pc_load && call.pc_addr == 16'h0003)
    else $error("ext0 vector wrong");

  a_last_cycle_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack |-> core.last_cycle)
    else $error("vectored mid instruction");

  a_flash_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core.flash_self_programming |-> !ack)
    else $error("call during flash programming");

  a_return_from_interrupt_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (core.return_from_interrupt || wr_priority) |-> !ack)
    else $error("call right after return or write");

  a_level_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack |-> !in_progress[1] && (sel_level || in_progress == 2'h0))
    else $error("preempted equal or higher level");

  a_uart_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack && sel_slot == 3'h4 && uart_receive_flag && !wr_flags |=> uart_receive_flag)
    else $error("uart flag cleared by hardware");

  a_timer_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack && sel_slot == 3'h1 && !timer0_overflow && !wr_flags |=> !timer0_overflow_flag)
    else $error("timer0 flag not cleared");

  a_return_from_interrupt_retire: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core.last_cycle && core.return_from_interrupt && in_progress == 2'h3 |=> in_progress == 2'h1)
    else $error("return did not clear high level");

  a_ret_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core.subroutine_exit && !core.return_from_interrupt && !ack |=> in_progress == $past(in_progress))
    else $error("plain exit changed in-progress");

  a_edge_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ext_edge_mode[0] && ext_fall[0] && !wr_flags |=> ext_flag[0])
    else $error("falling edge missed");

endmodule : irl_interrupt_response

//--- irl_core_model.sv
// Behavioural core: two-cycle instructions, stalled while a hardware call runs.
// Assumes the bench raises ret_req for as long as a return-from-interrupt executes.
module irl_core_model #(
  parameter logic [15:0] PC_VALUE = 16'hBE5A
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // Block side
  input  wire irl_pkg::irl_call_t call,
  output irl_pkg::irl_core_t      core,
  // Bench control
  input  wire logic               ret_req,
  input  wire logic               exit_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || call.busy) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // Fixed return address, so a swapped push order shows up
  assign core = '{opcode_fetch: ~phase & ~call.busy, last_cycle: phase & ~call.busy,
                  return_from_interrupt: ret_req, subroutine_exit: exit_req,
                  enable_priority_write: 1'b0, flash_self_programming: 1'b0, pc: PC_VALUE};
endmodule : irl_core_model

//--- tb.sv
// Self-checking bench for the interrupt response logic.
// Assumes one AHB-Lite slave and the behavioural core model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PC = 16'hBE5A;
  logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ret_req = 1'b0, exit_req = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'b00, pin_n = 2'b11, in_progress;
  logic        hreadyout, hresp;
  // Set pulses: timer0, timer1, uart rx, uart tx, low voltage
  logic [4:0]  setp = 5'h00;
  logic [15:0] vec, pushes;
  int          miscompares = 0, cmp_count = 0, loads = 0, busy_n = 0, cycles = 0;
  irl_pkg::irl_core_t core;
  irl_pkg::irl_call_t call;

  irl_interrupt_response irl_interrupt_response_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_request_pin_n(pin_n), .timer0_overflow(setp[0]), .timer1_overflow(setp[1]),
    .uart_receive_set(setp[2]), .uart_transmit_set(setp[3]), .low_voltage_set(setp[4]),
    .core(core), .call(call), .in_progress(in_progress));
  irl_core_model #(.PC_VALUE(PC)) irl_core_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .call(call), .core(core), .ret_req(ret_req), .exit_req(exit_req));

  always #12.5 clk_sys = ~clk_sys;

  // Sample registered call outputs away from the launching edge
  always @(negedge clk_sys) begin
    if (call.push === 1'b1) pushes = {call.push_byte, pushes[15:8]};
    if (call.pc_load === 1'b1) begin
      vec = call.pc_addr;
      loads++;
    end
    if (call.busy === 1'b1) busy_n++;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0); // Always OKAY
  endtask : bus

  task automatic pulse(input int i);
    setp[i] <= 1'b1;
    @(posedge clk_sys);
    setp[i] <= 1'b0;
  endtask : pulse

  // Waits for the vector load, then for the call to finish
  task automatic expect_call(input logic [15:0] v);
    for (int i = 0; i < 60 && loads == 0; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    check(loads, 1);
    check(vec, v);     // vector per source
    check(pushes, PC); // low byte then high
    check(busy_n, 6);  // six-cycle call
    loads = 0;
    busy_n = 0;
  endtask : expect_call

  // One return instruction, plain or from interrupt, aligned to a fetch
  task automatic do_return_from_interrupt(input logic plain, input logic [1:0] exp);
    do @(negedge clk_sys); while (core.last_cycle !== 1'b1);
    @(posedge clk_sys);
    if (plain) exit_req <= 1'b1;
    else ret_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ret_req <= 1'b0;
    exit_req <= 1'b0;
    @(negedge clk_sys);
    check(in_progress, exp); // level state after return
    @(posedge clk_sys);
  endtask : do_return_from_interrupt

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_timers();
    pulse(0);
    expect_call(16'h000B);
    bus(8'h08, 1'b0, 0);
    check(rd[5], 1'b0);           // timer flag cleared
    check(in_progress, 2'b01);    // low level busy
    do_return_from_interrupt(1'b1, 2'b01);         // plain exit keeps level
    pulse(1);
    repeat (30) @(posedge clk_sys);
    check(loads, 0);              // same level blocked
    do_return_from_interrupt(1'b0, 2'b00);         // level released
    expect_call(16'h001B);        // still-set flag served
    do_return_from_interrupt(1'b0, 2'b00);         // level released
  endtask : test_timers

  task automatic test_uart_lvd();
    pulse(2);
    expect_call(16'h0023);
    bus(8'h08, 1'b0, 0);
    check(rd[8], 1'b1);           // serial flag kept
    bus(8'h08, 1'b1, 32'h0000_0001);
    bus(8'h08, 1'b0, 0);
    check(rd[8], 1'b0);           // software clear
    do_return_from_interrupt(1'b0, 2'b00);         // level released
    pulse(3);
    expect_call(16'h0023);        // transmit shares serial vector
    bus(8'h08, 1'b0, 0);
    check(rd[9], 1'b1);           // transmit flag kept
    bus(8'h08, 1'b1, 32'h0000_0001);
    do_return_from_interrupt(1'b0, 2'b00);         // level released
    pulse(4);
    expect_call(16'h0033);
    bus(8'h08, 1'b1, 32'h0000_0001);
    do_return_from_interrupt(1'b0, 2'b00);         // level released
  endtask : test_uart_lvd

  task automatic test_ext_edge();
    // high then long low on the pin
    pin_n[0] <= 1'b0;
    expect_call(16'h0003);        // falling edge seen
    bus(8'h08, 1'b0, 0);
    check(rd[1], 1'b0);           // edge flag cleared
    pin_n[0] <= 1'b1;
    do_return_from_interrupt(1'b0, 2'b00);         // level released
  endtask : test_ext_edge

  task automatic test_ext_level();
    // level held low through the call and the flag read
    pin_n[1] <= 1'b0;
    expect_call(16'h0013);        // ext1 vector
    bus(8'h08, 1'b0, 0);
    check(rd[3], 1'b1);           // level flag not cleared
    pin_n[1] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    bus(8'h08, 1'b0, 0);
    check(rd[3], 1'b0);           // flag follows pin
    do_return_from_interrupt(1'b0, 2'b00);         // level released
    repeat (20) @(posedge clk_sys);
    check(loads, 0);              // no repeat after release
  endtask : test_ext_level

  task automatic test_preempt();
    bus(8'h04, 1'b1, 32'h0000_0002);
    pulse(2);
    expect_call(16'h0023);
    pulse(0);
    expect_call(16'h000B);        // high preempts low
    check(in_progress, 2'b11);    // both levels marked
    do_return_from_interrupt(1'b0, 2'b01);         // high level retires first
    bus(8'h08, 1'b1, 32'h0000_0001);
    do_return_from_interrupt(1'b0, 2'b00);         // low level released
  endtask : test_preempt

  task automatic report_and_stop();
    $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a <= 8'h20; a += 4) begin
      bus(8'(a), 1'b0, 0);
      check(rd, 0); // Reset values and unmapped read
    end
    bus(8'h00, 1'b1, 32'h0000_00DF);
    bus(8'h08, 1'b1, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    test_timers();
    test_uart_lvd();
    test_ext_edge();
    test_ext_level();
    test_preempt();
    report_and_stop();
  end
endmodule : tb
